//--- event_timers_params.svh
// Register indices, field positions, reset values and timing counts
`ifndef EVENT_TIMERS_PARAMS_SVH
`define EVENT_TIMERS_PARAMS_SVH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define IDX_TIMEBASE_FLAG_REG   6'h01
`define IDX_EVENT_FLAG_REG      6'h02
`define IDX_TIMEBASE_MODE       6'h08
`define IDX_EVENT_MODE_ONE      6'h09
`define IDX_EVENT_LOW           6'h0a
`define IDX_EVENT_HIGH          6'h0b
`define IDX_EVENT_OUT_MODE      6'h13
`define IDX_PIN_FUNC_C          6'h25
`define IDX_TIMEBASE_CTRL       6'h30

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define BIT_TIMEBASE_FLAG       2
`define BIT_EVENT_FLAG          0
`define BIT_TIMEBASE_SELECT     3
`define BIT_RELOAD_SELECT       3
`define BIT_EVENT_PIN_FUNC      0
`define BIT_TIMEBASE_CLEAR      0
`define SEL_EXTERNAL_EVENT      3'h7

// ------------------------------------------------------------------
// Reset values and timing counts
// ------------------------------------------------------------------
`define RST_NIBBLE              4'h0
`define RST_BYTE                8'h00
`define RST_OUT_MODE            2'h0
`define COUNT_ALL_ONES          8'hff
`define MODE_ONE_DELAY_CYCLES   2'h2
`define PRESCALER_S_WIDTH       11
`define PRESCALER_W_WIDTH       5

`endif

//--- event_timers_pkg.sv
// Types shared by the timebase and event timer block
package event_timers_pkg;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef enum logic [1:0] {
    OUT_PORT   = 2'h0,
    OUT_TOGGLE = 2'h1,
    OUT_LOW    = 2'h2,
    OUT_HIGH   = 2'h3
  } out_mode_t;

  typedef struct packed {
    logic       reload_select_bit;
    logic [2:0] clock_select;
  } event_mode_t;

endpackage : event_timers_pkg

//--- timebase_and_event_timers.sv
// Timebase timer and event timer with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "event_timers_params.svh"

module timebase_and_event_timers (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire event_timers_pkg::apb_req_t apb_req,
  output logic                           pready,
  output logic                           pslverr,
  output logic [31:0]                    prdata,
  input  wire logic                      crystal_32k_in,
  input  wire logic                      shared_port_event_pin,
  output logic                           event_timer_output_pin,
  output logic                           shared_port_output_sel,
  output logic                           timebase_overflow_flag,
  output logic                           event_timer_overflow_flag
);
  import event_timers_pkg::*;

  // ------------------------------------------------------------------
  // Tap decoding
  // ------------------------------------------------------------------
  // Log2 of the divide ratio for a prescaler S selection:
  // codes 0..3 step down by two from 11, codes 4..7 by one from 3
  function automatic logic [3:0] s_log2(input logic [2:0] sel);
    return sel[2] ? 4'(4'h7 - {1'b0, sel}) : 4'(4'hb - {sel, 1'b0});
  endfunction : s_log2
  // Pulse when the low k bits of the prescaler are all ones
  function automatic logic s_tap(input logic [10:0] cnt,
                                 input logic [3:0]  k);
    logic [10:0] mask;
    mask = 11'((12'h001 << k) - 12'h001);
    return (cnt & mask) == mask;
  endfunction : s_tap

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] evt_sync_ff;
  logic [2:0] xtal_sync_ff;
  logic       evt_level_ff;
  logic       xtal_level_ff;
  logic       nxt_evt_level;
  logic       nxt_xtal_level;
  logic       evt_fall;
  logic       xtal_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_sync_ff   <= 3'h7;
      xtal_sync_ff  <= 3'h0;
      evt_level_ff  <= 1'b1;
      xtal_level_ff <= 1'b0;
    end else begin
      evt_sync_ff   <= {evt_sync_ff[1:0], shared_port_event_pin};
      xtal_sync_ff  <= {xtal_sync_ff[1:0], crystal_32k_in};
      evt_level_ff  <= nxt_evt_level;
      xtal_level_ff <= nxt_xtal_level;
    end
  end

  // A level counts only once stages two and three agree
  always_comb begin
    nxt_evt_level  = evt_level_ff;
    nxt_xtal_level = xtal_level_ff;
    evt_fall       = 1'b0;
    xtal_rise      = 1'b0;
    if (evt_sync_ff[1] == evt_sync_ff[2]) begin
      nxt_evt_level = evt_sync_ff[2];
      evt_fall      = evt_level_ff & ~evt_sync_ff[2];
    end
    if (xtal_sync_ff[1] == xtal_sync_ff[2]) begin
      nxt_xtal_level = xtal_sync_ff[2];
      xtal_rise      = ~xtal_level_ff & xtal_sync_ff[2];
    end
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        nxt_pready;
  logic        nxt_pslverr;
  logic [31:0] nxt_prdata;
  logic        acc_first;
  logic        wr_done;
  logic        rd_high_now;
  logic [5:0]  idx;
  logic        addr_ok;
  // Register state
  logic [3:0]  timebase_mode_ff;
  logic [3:0]  nxt_timebase_mode;
  event_mode_t mode_one_ff;
  event_mode_t nxt_mode_one;
  event_mode_t mode_pend_ff;
  event_mode_t nxt_mode_pend;
  logic [1:0]  pend_cnt_ff;
  logic [1:0]  nxt_pend_cnt;
  logic [3:0]  load_low_ff;
  logic [3:0]  nxt_load_low;
  logic [3:0]  load_high_ff;
  logic [3:0]  nxt_load_high;
  logic [3:0]  count_latch_ff;
  logic [3:0]  nxt_count_latch;
  out_mode_t   out_mode_ff;
  out_mode_t   nxt_out_mode;
  logic [3:0]  pin_func_ff;
  logic [3:0]  nxt_pin_func;
  // Counters and flags
  logic [10:0] pres_s_ff;
  logic [4:0]  pres_w_ff;
  logic [7:0]  tb_count_ff;
  logic [7:0]  ev_count_ff;
  logic        tb_flag_ff;
  logic        ev_flag_ff;
  logic        out_pin_ff;
  logic        out_sel_ff;
  logic [10:0] nxt_pres_s;
  logic [4:0]  nxt_pres_w;
  logic [7:0]  nxt_tb_count;
  logic [7:0]  nxt_ev_count;
  logic        nxt_tb_flag;
  logic        nxt_ev_flag;
  logic        nxt_out_pin;
  logic        nxt_out_sel;

  // Request is answered one cycle into the access phase
  assign acc_first = apb_req.psel & apb_req.penable & ~pready_ff;
  assign wr_done   = apb_req.psel & apb_req.penable & pready_ff &
                     apb_req.pwrite & ~pslverr_ff;
  assign idx       = apb_req.paddr[7:2];
  assign addr_ok   = (apb_req.paddr[1:0] == 2'h0) &&
                     (idx inside {`IDX_TIMEBASE_FLAG_REG,
                                  `IDX_EVENT_FLAG_REG, `IDX_TIMEBASE_MODE,
                                  `IDX_EVENT_MODE_ONE, `IDX_EVENT_LOW,
                                  `IDX_EVENT_HIGH, `IDX_EVENT_OUT_MODE,
                                  `IDX_PIN_FUNC_C, `IDX_TIMEBASE_CTRL});
  assign rd_high_now = acc_first & ~apb_req.pwrite & addr_ok &
                       (idx == `IDX_EVENT_HIGH);

  // Read data is captured with the count of the same cycle
  always_comb begin
    nxt_pready  = acc_first;
    nxt_pslverr = acc_first & ~addr_ok;
    nxt_prdata  = prdata_ff;
    if (acc_first) begin
      nxt_prdata = 32'h0000_0000;
      if (!apb_req.pwrite && addr_ok) begin
        unique case (idx)
          `IDX_TIMEBASE_FLAG_REG:
            nxt_prdata[`BIT_TIMEBASE_FLAG] = tb_flag_ff;
          `IDX_EVENT_FLAG_REG:
            nxt_prdata[`BIT_EVENT_FLAG] = ev_flag_ff;
          `IDX_EVENT_LOW:
            nxt_prdata[3:0] = count_latch_ff;
          `IDX_EVENT_HIGH:
            nxt_prdata[3:0] = ev_count_ff[7:4];
          `IDX_EVENT_OUT_MODE:
            nxt_prdata[1:0] = out_mode_ff;
          default: ; // Write-only registers read zero
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata  = prdata_ff;

  // ------------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------------
  always_comb begin
    nxt_timebase_mode = timebase_mode_ff;
    nxt_mode_one      = mode_one_ff;
    nxt_mode_pend     = mode_pend_ff;
    nxt_pend_cnt      = pend_cnt_ff;
    nxt_load_low      = load_low_ff;
    nxt_load_high     = load_high_ff;
    nxt_out_mode      = out_mode_ff;
    nxt_pin_func      = pin_func_ff;
    nxt_count_latch   = count_latch_ff;
    if (rd_high_now) begin
      nxt_count_latch = ev_count_ff[3:0];
    end
    // A pending mode becomes the live one after its delay
    if (pend_cnt_ff != 2'h0) begin
      nxt_pend_cnt = 2'(pend_cnt_ff - 2'h1);
      if (pend_cnt_ff == 2'h1) begin
        nxt_mode_one = mode_pend_ff;
      end
    end
    if (wr_done) begin
      unique case (idx)
        `IDX_TIMEBASE_MODE: nxt_timebase_mode = apb_req.pwdata[3:0];
        `IDX_EVENT_MODE_ONE: begin
          nxt_mode_pend = event_mode_t'(apb_req.pwdata[3:0]);
          nxt_pend_cnt  = `MODE_ONE_DELAY_CYCLES;
        end
        `IDX_EVENT_LOW:      nxt_load_low = apb_req.pwdata[3:0];
        `IDX_EVENT_HIGH:     nxt_load_high = apb_req.pwdata[3:0];
        `IDX_EVENT_OUT_MODE: nxt_out_mode = out_mode_t'(apb_req.pwdata[1:0]);
        `IDX_PIN_FUNC_C:     nxt_pin_func = apb_req.pwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timebase_mode_ff <= `RST_NIBBLE;
      mode_one_ff      <= event_mode_t'(`RST_NIBBLE);
      mode_pend_ff     <= event_mode_t'(`RST_NIBBLE);
      pend_cnt_ff      <= 2'h0;
      load_low_ff      <= `RST_NIBBLE;
      load_high_ff     <= `RST_NIBBLE;
      count_latch_ff   <= `RST_NIBBLE;
      out_mode_ff      <= out_mode_t'(`RST_OUT_MODE);
      pin_func_ff      <= `RST_NIBBLE;
    end else begin
      timebase_mode_ff <= nxt_timebase_mode;
      mode_one_ff      <= nxt_mode_one;
      mode_pend_ff     <= nxt_mode_pend;
      pend_cnt_ff      <= nxt_pend_cnt;
      load_low_ff      <= nxt_load_low;
      load_high_ff     <= nxt_load_high;
      count_latch_ff   <= nxt_count_latch;
      out_mode_ff      <= nxt_out_mode;
      pin_func_ff      <= nxt_pin_func;
    end
  end

  // ------------------------------------------------------------------
  // Prescalers and timebase timer
  // ------------------------------------------------------------------
  logic       tb_select;
  logic       tb_clear;
  logic       tb_tick;
  logic       ev_tick;
  logic       ev_load;
  logic [2:0] w_k;
  assign tb_select = timebase_mode_ff[`BIT_TIMEBASE_SELECT];
  assign tb_clear  = wr_done & (idx == `IDX_TIMEBASE_CTRL) & tb_select &
                     apb_req.pwdata[`BIT_TIMEBASE_CLEAR];
  assign ev_load   = wr_done & (idx == `IDX_EVENT_HIGH);
  // Prescaler W tap: divide 32, 16, 8, 4, 2 of the 32 kHz input
  always_comb begin
    unique case (timebase_mode_ff[2:0])
      3'h1:    w_k = 3'h4;
      3'h2:    w_k = 3'h3;
      3'h3:    w_k = 3'h2;
      3'h4:    w_k = 3'h1;
      default: w_k = 3'h5;
    endcase
  end

  always_comb begin
    logic [4:0] wmask;
    wmask = 5'((6'h01 << w_k) - 6'h01);
    nxt_pres_s = 11'(pres_s_ff + 11'h001);
    nxt_pres_w = xtal_rise ? 5'(pres_w_ff + 5'h01) : pres_w_ff;
    if (tb_select) begin
      tb_tick = xtal_rise & ((pres_w_ff & wmask) == wmask);
    end else begin
      tb_tick = s_tap(pres_s_ff, s_log2(timebase_mode_ff[2:0]));
    end
    nxt_tb_count = tb_count_ff;
    nxt_tb_flag  = tb_flag_ff;
    // Software writes zero to clear; a same-cycle overflow still sets
    if (wr_done && idx == `IDX_TIMEBASE_FLAG_REG &&
        !apb_req.pwdata[`BIT_TIMEBASE_FLAG]) begin
      nxt_tb_flag = 1'b0;
    end
    if (tb_tick) begin
      nxt_tb_count = 8'(tb_count_ff + 8'h01);
      if (tb_count_ff == `COUNT_ALL_ONES) begin
        nxt_tb_flag = 1'b1;
      end
    end
    if (tb_clear) begin
      nxt_pres_w   = 5'h00;
      nxt_tb_count = `RST_BYTE;
    end
  end

  // ------------------------------------------------------------------
  // Event timer and output pin
  // ------------------------------------------------------------------
  always_comb begin
    if (mode_one_ff.clock_select == `SEL_EXTERNAL_EVENT) begin
      // Counting needs the shared pin routed to event input
      ev_tick = evt_fall & pin_func_ff[`BIT_EVENT_PIN_FUNC];
    end else begin
      ev_tick = s_tap(pres_s_ff, s_log2(mode_one_ff.clock_select));
    end
    nxt_ev_count = ev_count_ff;
    nxt_ev_flag  = ev_flag_ff;
    nxt_out_pin  = out_pin_ff;
    nxt_out_sel  = (out_mode_ff != OUT_PORT);
    if (wr_done && idx == `IDX_EVENT_FLAG_REG &&
        !apb_req.pwdata[`BIT_EVENT_FLAG]) begin
      nxt_ev_flag = 1'b0;
    end
    if (ev_tick) begin
      nxt_ev_count = 8'(ev_count_ff + 8'h01);
      if (ev_count_ff == `COUNT_ALL_ONES) begin
        nxt_ev_flag = 1'b1;
        if (mode_one_ff.reload_select_bit) begin
          nxt_ev_count = {load_high_ff, load_low_ff};
        end else begin
          nxt_ev_count = `RST_BYTE;
        end
        unique case (out_mode_ff)
          OUT_TOGGLE: nxt_out_pin = ~out_pin_ff;
          OUT_LOW:    nxt_out_pin = 1'b0;
          OUT_HIGH:   nxt_out_pin = 1'b1;
          OUT_PORT:   nxt_out_pin = out_pin_ff;
        endcase
      end
    end
    // Software load wins over a tick in the same cycle
    if (ev_load) begin
      nxt_ev_count = {apb_req.pwdata[3:0], load_low_ff};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pres_s_ff   <= 11'h000;
      pres_w_ff   <= 5'h00;
      tb_count_ff <= `RST_BYTE;
      ev_count_ff <= `RST_BYTE;
      tb_flag_ff  <= 1'b0;
      ev_flag_ff  <= 1'b0;
      out_pin_ff  <= 1'b0;
      out_sel_ff  <= 1'b0;
    end else begin
      pres_s_ff   <= nxt_pres_s;
      pres_w_ff   <= nxt_pres_w;
      tb_count_ff <= nxt_tb_count;
      ev_count_ff <= nxt_ev_count;
      tb_flag_ff  <= nxt_tb_flag;
      ev_flag_ff  <= nxt_ev_flag;
      out_pin_ff  <= nxt_out_pin;
      out_sel_ff  <= nxt_out_sel;
    end
  end

  assign event_timer_output_pin    = out_pin_ff;
  assign shared_port_output_sel    = out_sel_ff;
  assign timebase_overflow_flag    = tb_flag_ff;
  assign event_timer_overflow_flag = ev_flag_ff;

endmodule : timebase_and_event_timers

`default_nettype wire

//--- tbet_asserts.sv
// Checker for the timer block bus handshake, flags and output pin
`timescale 1ns/1ps
`default_nettype none
module tbet_asserts (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire event_timers_pkg::apb_req_t apb_req,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic [31:0]                prdata,
  input wire logic                       event_timer_output_pin,
  input wire logic                       shared_port_output_sel,
  input wire logic                       timebase_overflow_flag,
  input wire logic                       event_timer_overflow_flag
);
  import event_timers_pkg::*;
  logic       wr_done;
  logic       rd_done;
  logic       wr_om;
  logic [1:0] om_ff;
  logic [2:0] tb_clr_ff;
  logic [2:0] ev_clr_ff;
  assign wr_done = apb_req.psel & apb_req.penable & apb_req.pwrite & pready;
  assign rd_done = apb_req.psel & apb_req.penable & ~apb_req.pwrite & pready;
  assign wr_om   = wr_done & (apb_req.paddr == 8'h4c);
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  // Flag copies lag the clearing write, so remember three cycles of clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      om_ff     <= 2'h0;
      tb_clr_ff <= 3'h0;
      ev_clr_ff <= 3'h0;
    end else begin
      if (wr_om)
        om_ff <= apb_req.pwdata[1:0];
      tb_clr_ff <= {tb_clr_ff[1:0],
                    wr_done & (apb_req.paddr == 8'h04) & ~apb_req.pwdata[2]};
      ev_clr_ff <= {ev_clr_ff[1:0],
                    wr_done & (apb_req.paddr == 8'h08) & ~apb_req.pwdata[0]};
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (apb_req.psel && apb_req.penable && !pready
    |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_misalign: assert property (pready && apb_req.paddr[1:0] != 2'h0
    |-> pslverr) else $error("misaligned access not refused");
  a_mapped_ok: assert property (pready && apb_req.paddr == 8'h28 |-> !pslverr)
    else $error("mapped access refused");
  a_wo_reads_zero: assert property (rd_done &&
    apb_req.paddr inside {8'h20, 8'h24, 8'h94, 8'hc0} |-> prdata == 32'h0)
    else $error("write-only register read nonzero");
  a_outmode_read: assert property (rd_done &&
    apb_req.paddr == 8'h4c |-> prdata == {30'h0, om_ff})
    else $error("output mode readback wrong");
  a_outsel_follow: assert property (wr_om
    |-> ##2 shared_port_output_sel == (om_ff != 2'h0))
    else $error("pin handover wrong");
  a_pin_port_hold: assert property (!shared_port_output_sel &&
    !$past(shared_port_output_sel) |-> $stable(event_timer_output_pin))
    else $error("output pin moved in port mode");
  a_ev_flag_clear: assert property ($fell(event_timer_overflow_flag)
    |-> ev_clr_ff != 3'h0) else $error("event flag fell without clear");
  a_tb_flag_clear: assert property ($fell(timebase_overflow_flag)
    |-> tb_clr_ff != 3'h0) else $error("timebase flag fell without clear");
endmodule : tbet_asserts

bind timebase_and_event_timers tbet_asserts u_chk (.pclk(pclk),
  .presetn(presetn), .apb_req(apb_req), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .event_timer_output_pin(event_timer_output_pin),
  .shared_port_output_sel(shared_port_output_sel),
  .timebase_overflow_flag(timebase_overflow_flag),
  .event_timer_overflow_flag(event_timer_overflow_flag));
`default_nettype wire

//--- event_partner.sv
// Far-side model: free-running crystal and the pulled-up event pin
`timescale 1ns/1ps
`default_nettype none
module event_partner (
  input  wire logic clk,
  output logic      xtal,
  output logic      evt
);
  // Crystal runs free, unrelated in phase to the bus clock
  initial begin
    xtal = 1'b0;
    forever #190 xtal = ~xtal;
  end
  initial evt = 1'b1;
  // Each level held four cycles so the synchroniser cannot miss it
  task automatic fall(input int n);
    repeat (n) begin
      @(posedge clk);
      evt <= 1'b0;
      repeat (4) @(posedge clk);
      evt <= 1'b1;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : fall
endmodule : event_partner
`default_nettype wire

//--- timebase_and_event_timers_tb.sv
// Self-checking bench for the timebase and event timers
`timescale 1ns/1ps
`default_nettype none
module timebase_and_event_timers_tb;
  import event_timers_pkg::*;
  apb_req_t    req;
  logic        pclk, presetn, pready, pslverr, xtal, evt;
  logic        pin, osel, tfl, efl;
  logic [31:0] prdata, rnd;
  logic [33:0] exp_e;
  logic [33:0] expq[$];
  int          n_errors, comparisons, cyc, t0;

  timebase_and_event_timers DUT (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .crystal_32k_in(xtal), .shared_port_event_pin(evt),
    .event_timer_output_pin(pin), .shared_port_output_sel(osel),
    .timebase_overflow_flag(tfl), .event_timer_overflow_flag(efl));
  event_partner u_part (.clk(pclk), .xtal(xtal), .evt(evt));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic close_out;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Expectation is queued first; the monitor matches it at pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic err);
    logic [31:0] junk;
    // Upper write bits carry noise; only the low nibble may matter
    junk = xs(rnd ^ {24'h0, a});
    expq.push_back({w, err, d});
    @(posedge pclk);
    req.psel   <= 1'b1;
    req.pwrite <= w;
    req.paddr  <= a;
    req.pwdata <= w ? {junk[31:4], d[3:0]} : d;
    @(posedge pclk);
    req.penable <= 1'b1;
    // Wait ends when pready is seen high; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, e, 1'b0);
  endtask : rd

  // Skip the lagging flag copy before watching for the next set
  task automatic wait_tfl;
    int n;
    n = 0;
    repeat (3) @(posedge pclk);
    while (tfl !== 1'b1 && n < 9000) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_tfl

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (pready === 1'b1) begin
      exp_e = expq.pop_front();
      chk("pslverr", {31'h0, exp_e[32]}, {31'h0, pslverr});
      if (!exp_e[33])
        chk("prdata", exp_e[31:0], prdata);
    end
  end

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    #(30000 * 50);
    n_errors++;
    close_out();
  end

  initial begin
    req = '0;
    presetn = 1'b0;
    rnd = 32'h72c6;
    cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("output pin", 32'h0, {31'h0, pin});
    rd(8'h4c, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h08, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      wr(8'h4c, rnd);
      rd(8'h4c, {30'h0, rnd[1:0]});
    end
    apb(1'b0, 8'hfc, 32'h0, 1'b1);
    apb(1'b1, 8'h4d, 32'h1, 1'b1);
    rd(8'h4c, {30'h0, rnd[1:0]});
    $display("test registers done");
    wr(8'h4c, 32'h1);
    repeat (3) @(posedge pclk);
    chk("output select", 32'h1, {31'h0, osel});
    wr(8'h94, 32'h1);
    wr(8'h24, 32'hf);
    wr(8'h28, 32'hd);
    wr(8'h2c, 32'hf);
    u_part.fall(1);
    rd(8'h2c, 32'hf);
    u_part.fall(1);
    rd(8'h28, 32'he);
    wr(8'h28, 32'h3);
    rd(8'h2c, 32'hf);
    rd(8'h28, 32'hf);
    u_part.fall(1);
    rd(8'h2c, 32'hf);
    rd(8'h28, 32'h3);
    rd(8'h08, 32'h1);
    chk("event flag", 32'h1, {31'h0, efl});
    chk("toggle out", 32'h1, {31'h0, pin});
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h4c, 32'h2);
    wr(8'h28, 32'he);
    wr(8'h2c, 32'hf);
    u_part.fall(2);
    chk("zero out", 32'h0, {31'h0, pin});
    wr(8'h4c, 32'h3);
    u_part.fall(2);
    chk("one out", 32'h1, {31'h0, pin});
    wr(8'h24, 32'h7);
    u_part.fall(2);
    rd(8'h2c, 32'h0);
    rd(8'h28, 32'h0);
    wr(8'h4c, 32'h0);
    repeat (3) @(posedge pclk);
    chk("output select", 32'h0, {31'h0, osel});
    $display("test event timer done");
    wr(8'h20, 32'h7);
    wr(8'h04, 32'h0);
    wait_tfl();
    t0 = cyc;
    wr(8'h04, 32'h0);
    wait_tfl();
    chk("timebase period", 32'h100, cyc - t0);
    wr(8'h20, 32'hc);
    wr(8'hc0, 32'h1);
    t0 = cyc;
    wr(8'h04, 32'h0);
    wait_tfl();
    chk("crystal period", 32'h1,
        {31'h0, (cyc - t0) inside {[3850:3940]}});
    $display("test timebase done");
    close_out();
  end
endmodule : timebase_and_event_timers_tb
`default_nettype wire
